// ### include/interval_timer_cfg.svh
// Address map, field positions, reset values and widths of the interval timer.
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH

// Printed register offsets; the low six bits form the word index on the bus.
`define CSR_OFFSET 32'hffff862c
`define CNT_OFFSET 32'hffff862e
`define COR_OFFSET 32'hffff8630
// Interrupt status and mask registers placed after the timer registers.
`define IRQ_STATUS_OFFSET 32'hffff8632
`define IRQ_MASK_OFFSET 32'hffff8634
// Width of the word index decoded from adr_i[7:2].
`define INDEX_W 6

// Bus widths.
`define ADR_W 8
`define DAT_W 32
`define SEL_W 4
`define REG_W 16

// Control/status field positions.
`define CSR_FLAG_BIT 6
`define CSR_IE_BIT 5
`define CSR_PS_HI 4
`define CSR_PS_LO 2

// Interrupt status and mask field position of the match event.
`define IRQ_MATCH_BIT 0

// Reset values.
`define CSR_RESET 16'h0000
`define CNT_RESET 8'h00
`define COR_RESET 8'h00
`define IRQ_RESET 1'b0

// Counter and prescaler widths; the deepest division is two to the twelfth.
`define COUNT_W 8
`define PRESCALE_W 12
`define DIV_TAPS 7

`endif

// ### include/interval_timer_pkg.sv
// Types shared by the interval timer files.
package interval_timer_pkg;

	// Input clock selection codes.
	typedef enum logic [2:0] {
		PS_STOP = 3'b000,
		PS_DIV2 = 3'b001,
		PS_DIV8 = 3'b010,
		PS_DIV32 = 3'b011,
		PS_DIV128 = 3'b100,
		PS_DIV512 = 3'b101,
		PS_DIV2048 = 3'b110,
		PS_DIV4096 = 3'b111
	} prescale_sel_t;

	// Registers reached through the bus decoder.
	typedef enum logic [2:0] {
		SLOT_CSR = 3'b000,
		SLOT_CNT = 3'b001,
		SLOT_COR = 3'b010,
		SLOT_IRQ_STATUS = 3'b011,
		SLOT_IRQ_MASK = 3'b100,
		SLOT_NONE = 3'b111
	} reg_slot_t;

endpackage

// ### rtl/prescale_divider.sv
// Free-running prescaler that issues one-cycle count ticks.
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"

module prescale_divider (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Selected division.
	input wire interval_timer_pkg::prescale_sel_t sel_i,
	// Count tick, one cycle wide.
	output logic tick_o
);
	import interval_timer_pkg::*;

	// Number of low bits that must all be ones for each division.
	function automatic int tap_bits(input int idx);
		case (idx)
			0: tap_bits = 1;
			1: tap_bits = 3;
			2: tap_bits = 5;
			3: tap_bits = 7;
			4: tap_bits = 9;
			5: tap_bits = 11;
			default: tap_bits = 12;
		endcase
	endfunction

	// Shared divider chain; every division is a terminal count of it.
	logic [`PRESCALE_W-1:0] div_reg;
	// Terminal count of each division.
	logic [`DIV_TAPS-1:0] tap;
	// Registered tick.
	logic tick_reg;

	// The chain runs from reset onward so that all divisions stay in phase.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + `PRESCALE_W'(1);
		end
	end

	// One tap per division.
	genvar g;
	generate
		for (g = 0; g < `DIV_TAPS; g++) begin : g_tap
			assign tap[g] = &div_reg[tap_bits(g)-1:0];
		end
	endgenerate

	// Code zero stops the count; codes one to seven pick a tap.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_reg <= 1'b0;
		end else if (sel_i == PS_STOP) begin
			tick_reg <= 1'b0; // [R2]
		end else begin
			tick_reg <= tap[3'(sel_i) - 3'd1]; // [R2]
		end
	end

	assign tick_o = tick_reg;

endmodule // prescale_divider

// ### rtl/interval_timer_unit.sv
// Eight-bit compare interval timer with a classic Wishbone register slave.
//
// Notes on behaviour
// R1: Counter is eight bits in the low byte.
// R2: Select zero stops; others divide 2 to 4096.
// R3: On equality counter clears and flag sets.
// R4: After clearing, counting resumes from zero.
// R5: Interrupt request is flag AND enable.
// R6: Request stays high until flag clears.
// R7: Flag clears by read-one then write-zero.
// R8: No match while both hold reset values; kept only until a counter or period write or a count tick.
// R9: Match acts at the next count tick.
// R10: Counter readable and writable at any time.
// R11: Reserved status bits read zero.
// R12: Counter upper byte reads zero.
// R13: Period upper byte reads zero, ignored.
// R14: Reset clears status, counter and period.
// R15: Hardware set beats software clear.
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"

module interval_timer_unit (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [`ADR_W-1:0] adr_i,
	input wire logic [`SEL_W-1:0] sel_i,
	input wire logic [`DAT_W-1:0] dat_i,
	output logic [`DAT_W-1:0] dat_o,
	output logic ack_o,
	// Interrupts.
	output logic match_interrupt_o,
	output logic irq_o
);
	import interval_timer_pkg::*;

	// Printed offsets; the low bits are the word index.
	localparam logic [31:0] csr_off = `CSR_OFFSET;
	localparam logic [31:0] cnt_off = `CNT_OFFSET;
	localparam logic [31:0] cor_off = `COR_OFFSET;
	localparam logic [31:0] ist_off = `IRQ_STATUS_OFFSET;
	localparam logic [31:0] imk_off = `IRQ_MASK_OFFSET;

	// Maps a word index to the register it selects.
	function automatic reg_slot_t decode_slot(
		input logic [`INDEX_W-1:0] idx);
		if (idx == csr_off[`INDEX_W-1:0]) begin
			decode_slot = SLOT_CSR;
		end else if (idx == cnt_off[`INDEX_W-1:0]) begin
			decode_slot = SLOT_CNT;
		end else if (idx == cor_off[`INDEX_W-1:0]) begin
			decode_slot = SLOT_COR;
		end else if (idx == ist_off[`INDEX_W-1:0]) begin
			decode_slot = SLOT_IRQ_STATUS;
		end else if (idx == imk_off[`INDEX_W-1:0]) begin
			decode_slot = SLOT_IRQ_MASK;
		end else begin
			decode_slot = SLOT_NONE;
		end
	endfunction

	// Timer state.
	logic flag_reg; // Compare-match flag.
	logic ie_reg; // Match interrupt enable.
	prescale_sel_t ps_reg; // Input clock selection.
	logic [`COUNT_W-1:0] cnt_reg; // Up-counter.
	logic [`COUNT_W-1:0] cor_reg; // Period value.
	logic touched_reg; // Counter or period written, or a count tick seen, since reset.
	logic armed_reg; // Flag was read as one since the last control write.
	// Interrupt status and mask.
	logic irq_status_reg;
	logic irq_mask_reg;
	// Bus answer.
	logic ack_reg;
	logic [`DAT_W-1:0] dat_reg;
	// Interrupt outputs.
	logic match_irq_reg;
	logic irq_reg;

	// Next values used for both the state and the registered outputs.
	logic flag_next;
	logic irq_status_next;

	// Bus decode.
	logic access; // A new request taken this cycle.
	logic wr_low; // Write with the low byte lane enabled.
	logic rd; // Read request.
	reg_slot_t slot;

	// Count tick and match detection.
	logic tick;
	logic match_now;

	// Prescaler supplies the selected count tick.
	prescale_divider u_prescale (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sel_i(ps_reg),
		.tick_o(tick)
	);

	// A request is taken once; ack high blocks a second take.
	assign access = cyc_i & stb_i & ~ack_reg;
	assign wr_low = access & we_i & sel_i[0];
	assign rd = access & ~we_i;
	assign slot = decode_slot(adr_i[`INDEX_W+1:2]);

	// Match is only acted on as the counter is about to move.
	assign match_now = tick & touched_reg & (cnt_reg == cor_reg); // [R3] [R8] [R9]

	// The answer follows one cycle after the request and lasts one cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= access;
		end
	end

	// Read data is captured when the request is taken.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= '0;
		end else if (rd) begin
			case (slot)
				SLOT_CSR: begin
					// Reserved bits are padded with zeros.
					dat_reg <= {25'h0000000, flag_reg, ie_reg,
						ps_reg, 2'b00}; // [R11]
				end
				SLOT_CNT: begin
					dat_reg <= {24'h000000, cnt_reg}; // [R10] [R12]
				end
				SLOT_COR: begin
					dat_reg <= {24'h000000, cor_reg}; // [R13]
				end
				SLOT_IRQ_STATUS: begin
					dat_reg <= {31'h00000000, irq_status_reg};
				end
				SLOT_IRQ_MASK: begin
					dat_reg <= {31'h00000000, irq_mask_reg};
				end
				default: begin
					// Unmapped addresses read as zero.
					dat_reg <= '0;
				end
			endcase
		end else if (ack_reg) begin
			// Data is returned to zero once the answer is over.
			dat_reg <= '0;
		end
	end

	// Control fields: enable and clock select.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_reg <= 1'b0; // [R14]
			ps_reg <= PS_STOP; // [R14]
		end else if (wr_low && slot == SLOT_CSR) begin
			ie_reg <= dat_i[`CSR_IE_BIT];
			ps_reg <= prescale_sel_t'(dat_i[`CSR_PS_HI:`CSR_PS_LO]);
		end
	end

	// Flag next value: a match wins over the clearing write.
	always_comb begin
		flag_next = flag_reg;
		if (wr_low && slot == SLOT_CSR && !dat_i[`CSR_FLAG_BIT]
			&& armed_reg) begin
			// Writing zero only clears after a read that saw one.
			flag_next = 1'b0; // [R7]
		end
		if (match_now) begin
			flag_next = 1'b1; // [R3] [R15]
		end
	end

	// Compare-match flag.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= 1'b0; // [R14]
		end else begin
			flag_reg <= flag_next;
		end
	end

	// Remembers that software saw the flag set before it writes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_reg <= 1'b0;
		end else if (wr_low && slot == SLOT_CSR) begin
			// Any control write uses up the read.
			armed_reg <= 1'b0; // [R7]
		end else if (rd && slot == SLOT_CSR && flag_reg) begin
			armed_reg <= 1'b1; // [R7]
		end
	end

	// Counter: a bus write beats a count tick in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= `CNT_RESET; // [R14]
		end else if (wr_low && slot == SLOT_CNT) begin
			// Upper byte lanes carry no count bits.
			cnt_reg <= dat_i[`COUNT_W-1:0]; // [R1] [R10] [R12]
		end else if (match_now) begin
			cnt_reg <= '0; // [R3]
		end else if (tick) begin
			// After a clear the count goes on from zero.
			cnt_reg <= cnt_reg + `COUNT_W'(1); // [R1] [R4]
		end
	end

	// Period register; only the low byte takes part in the compare.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cor_reg <= `COR_RESET; // [R14]
		end else if (wr_low && slot == SLOT_COR) begin
			cor_reg <= dat_i[`COUNT_W-1:0]; // [R13]
		end
	end

	// Marks that the counter or period was written, or a count tick came, since reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			touched_reg <= 1'b0;
		end else if (wr_low && (slot == SLOT_CNT || slot == SLOT_COR)) begin
			touched_reg <= 1'b1; // [R8]
		end else if (tick && !match_now) begin
			// An increment also counts as a change.
			touched_reg <= 1'b1; // [R8]
		end
	end

	// Status next value: a match wins over the clearing read.
	always_comb begin
		irq_status_next = irq_status_reg;
		if (rd && slot == SLOT_IRQ_STATUS) begin
			irq_status_next = 1'b0;
		end
		if (match_now) begin
			irq_status_next = 1'b1;
		end
	end

	// Sticky status of match events.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_reg <= `IRQ_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	// Mask of the status bits allowed onto irq_o.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= `IRQ_RESET;
		end else if (wr_low && slot == SLOT_IRQ_MASK) begin
			irq_mask_reg <= dat_i[`IRQ_MATCH_BIT];
		end
	end

	// Request toward the interrupt controller, held as a level.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_irq_reg <= 1'b0;
		end else if (wr_low && slot == SLOT_CSR) begin
			// Use the enable that this write is storing.
			match_irq_reg <= flag_next & dat_i[`CSR_IE_BIT]; // [R5] [R6]
		end else begin
			match_irq_reg <= flag_next & ie_reg; // [R5] [R6]
		end
	end

	// Summary interrupt from masked status.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else if (wr_low && slot == SLOT_IRQ_MASK) begin
			irq_reg <= irq_status_next & dat_i[`IRQ_MATCH_BIT];
		end else begin
			irq_reg <= irq_status_next & irq_mask_reg;
		end
	end

	// Outputs come straight from flip-flops.
	assign dat_o = dat_reg;
	assign ack_o = ack_reg;
	assign match_interrupt_o = match_irq_reg;
	assign irq_o = irq_reg;

endmodule // interval_timer_unit

// ### verif/timer_checker.sv
// Port property checker for the interval timer, bound to its top module.
`timescale 1ns/1ps
module timer_checker (
	// Clock, reset and bus inputs.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	// Outputs of the timer.
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic match_interrupt_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A request that the slave takes at this edge.
	sequence take_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	// A read of one register address.
	sequence rd_s(a);
		take_s ##0 !we_i && adr_i == a;
	endsequence
	// A byte-zero write of one register address.
	sequence wr_s(a);
		take_s ##0 we_i && sel_i[0] && adr_i == a;
	endsequence
	ack_next_a: assert property (take_s |=> ack_o)
		else $error("request not acknowledged");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	csr_resv_a: assert property (rd_s(8'hb0) |=> dat_o[31:7] == 25'h0 && dat_o[1:0] == 2'h0)
		else $error("reserved control bits not zero");
	cnt_upper_a: assert property (rd_s(8'hb8) |=> dat_o[31:8] == 24'h0)
		else $error("counter upper bits not zero");
	cor_upper_a: assert property (rd_s(8'hc0) |=> dat_o[31:8] == 24'h0)
		else $error("period upper bits not zero");
	ie_off_a: assert property (wr_s(8'hb0) ##0 !dat_i[5] |=> !match_interrupt_o)
		else $error("interrupt with enable off");
	int_hold_a: assert property ($fell(match_interrupt_o) |-> $past(cyc_i && stb_i && we_i))
		else $error("interrupt dropped without a write");
	mask_off_a: assert property (wr_s(8'hd0) ##0 !dat_i[0] |=> !irq_o)
		else $error("masked interrupt raised");
	reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !match_interrupt_o)
		else $error("outputs active after reset");
endmodule // timer_checker

bind interval_timer_unit timer_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .match_interrupt_o, .irq_o);

// ### verif/irq_sink.sv
// Interrupt controller model that counts rises of a level request.
`timescale 1ns/1ps
module irq_sink (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Level request and its count of rises.
	input wire logic req_i,
	output int rises_o
);
	logic last_reg; // Request level at the previous edge.
	// A held level counts once, so a request that drops early shows up twice.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_reg <= 1'b0;
			rises_o <= 0;
		end else begin
			last_reg <= req_i;
			rises_o <= rises_o + int'(req_i && !last_reg);
		end
	end
endmodule // irq_sink

// ### verif/tb_interval_timer_unit.sv
// Self-checking bench for the interval timer.
`timescale 1ns/1ps
module tb_interval_timer_unit;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 0, p;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd, a;
	logic ack_o, match_interrupt_o, irq_o;
	int rises, failures = 0, total_checks = 0, seed = 51830, cycles = 0;
	interval_timer_unit dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .match_interrupt_o, .irq_o);
	irq_sink sink_u (.clk_i, .rst_i, .req_i(match_interrupt_o), .rises_o(rises));
	// System clock, 100 ns period.
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// Division of a select code; code zero gets a plain idle wait.
	function automatic int div_of(input int c);
		return c == 0 ? 16 : (c == 7 ? 4096 : 1 << (2 * c - 1));
	endfunction
	// Prints the verdict and ends the run.
	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Compares one value and counts the outcome.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic bus cycle, held until ack is sampled.
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= ad;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		if (n >= 50)
			failures++;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1, ad, d, 4'hf);
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input string nm);
		bus(0, ad, 32'h0, 4'hf);
		chk(nm, e, rd);
	endtask
	// Waits a bounded time for the match request.
	task automatic wait_int(input int lim);
		for (int n = 0; n < lim && match_interrupt_o !== 1'b1; n++)
			@(posedge clk_i);
	endtask
	// Cuts a hang short.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 40000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		rdc(8'hb0, 0, "csr_reset");
		rdc(8'hb8, 0, "cnt_reset");
		rdc(8'hc0, 0, "cor_reset");
		wr(8'hb0, 32'hffffff83);
		rdc(8'hb0, 0, "csr_reserved");
		rdc(8'he0, 0, "unmapped");
		// Equal at start: the match waits for the next slow tick.
		wr(8'hc0, 5);
		wr(8'hb8, 5);
		wr(8'hb0, 32'h3c);
		repeat (30) @(posedge clk_i);
		rdc(8'hb0, 32'h3c, "flag_early");
		wait_int(4200);
		chk("int_set", 1, match_interrupt_o);
		chk("irq_masked", 0, irq_o);
		rdc(8'hb8, 0, "cnt_cleared");
		wr(8'hb0, 32'h3c);
		chk("clear_unread", 1, match_interrupt_o);
		wr(8'hb0, 32'h1c);
		chk("ie_off", 0, match_interrupt_o);
		wr(8'hb0, 32'h3c);
		chk("ie_on", 1, match_interrupt_o);
		wr(8'hd0, 1);
		chk("irq_unmasked", 1, irq_o);
		rdc(8'hb0, 32'h7c, "flag_read");
		wr(8'hb0, 32'h3c);
		chk("flag_clear", 0, match_interrupt_o);
		chk("irq_sticky", 1, irq_o);
		rdc(8'hc8, 1, "status_read");
		chk("irq_cleared", 0, irq_o);
		rdc(8'hc8, 0, "status_empty");
		// The enable was turned off and on again, so the level rose twice.
		chk("rises", 2, rises);
		// Counter and period hold any value, upper bytes dropped.
		wr(8'hb0, 0);
		for (int i = 0; i < 4; i++) begin
			a = $random(seed);
			wr(8'hb8, a);
			bus(1, 8'hb8, ~a, 4'he);
			rdc(8'hb8, {24'h0, a[7:0]}, "cnt_rw");
			wr(8'hc0, ~a);
			rdc(8'hc0, {24'h0, ~a[7:0]}, "cor_rw");
		end
		// Every select code, rate taken between two running reads.
		wr(8'hc0, 32'hff);
		for (int c = 0; c < 8; c++) begin
			wr(8'hb8, 0);
			wr(8'hb0, c << 2);
			// The old and new selects may tick up to three times between the clear and the read.
			bus(0, 8'hb8, 32'h0, 4'hf);
			chk("cnt_live", 1, 32'(rd <= 3));
			a = rd;
			repeat (2 * div_of(c) - 3) @(posedge clk_i);
			rdc(8'hb8, a + (c == 0 ? 0 : 2), "rate");
		end
		// Cyclic run at the fastest rate with a random period.
		p = 8'(2 + ($random(seed) & 7));
		wr(8'hb0, 0);
		wr(8'hc0, p);
		wr(8'hb8, 0);
		wr(8'hb0, 32'h24);
		repeat (6 * p + 8) @(posedge clk_i);
		bus(0, 8'hb8, 0, 4'hf);
		chk("cnt_cyclic", 1, rd <= p);
		chk("int_cyclic", 1, match_interrupt_o);
		give_verdict();
	end
endmodule // tb_interval_timer_unit
